// ### verilog/gpr_regs.svh
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH
`define GPR_OFF_A_OUT     8'h00
`define GPR_OFF_A_DIR     8'h04
`define GPR_OFF_A_PU      8'h08
`define GPR_OFF_A_IN      8'h0c
`define GPR_OFF_B_OUT     8'h10
`define GPR_OFF_B_DIR     8'h14
`define GPR_OFF_B_PU      8'h18
`define GPR_OFF_B_IN      8'h1c
`define GPR_OFF_RST_CTRL  8'h20
`define GPR_OFF_RST_STAT  8'h24
`define GPR_RST_LATCH_BIT 0
`define GPR_RST_SWREQ_BIT 1
`define GPR_RST_DONE_BIT  0
`define GPR_RST_ACT_BIT   1
`define GPR_STAB_NS       1000
`define GPR_CLK_NS        10
`define GPR_STAB_CYC      ((`GPR_STAB_NS + `GPR_CLK_NS - 1) / `GPR_CLK_NS)
`define GPR_SWRST_NS      500
`define GPR_SWRST_CYC     ((`GPR_SWRST_NS + `GPR_CLK_NS - 1) / `GPR_CLK_NS)
`endif

// ### verilog/gpr_pkg.sv
package gpr_pkg;
	typedef enum logic [1:0] {
		GPR_ST_HOLD = 2'b00,
		GPR_ST_WAIT = 2'b01,
		GPR_ST_RUN  = 2'b11,
		GPR_ST_SWRST = 2'b10
	} gpr_state_e;
	typedef struct packed {
		logic [6:0] a_out;
		logic [6:0] a_dir;
		logic [6:0] a_pu;
		logic [4:0] b_out;
		logic [4:0] b_dir;
		logic [4:0] b_pu;
		logic       rst_latch;
	} gpr_cfg_s;
	typedef struct packed {
		logic        wr_done;
		logic        rd_done;
		logic [31:0] rdata;
		logic [1:0]  bresp;
		logic [1:0]  rresp;
	} gpr_bus_s;
endpackage

// ### verilog/gpr_top.sv
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "gpr_regs.svh"
// Notes on behaviour
// - port a: seven independent tri-state bits
// - port b: five independent tri-state bits
// - per-bit direction register on each port
// - per-bit pull-up register on each port
// - reset: all inputs, pull-ups off
// - reset pin low holds everything initialised
// - after release, wait clock stabilisation first
// - latch zero plus software reset drives pin low
// - reset pin output is open-drain only
module gpr_top import gpr_pkg::*; #(
	parameter int A_W      = 7,
	parameter int B_W      = 5,
	parameter int STAB_CYC = `GPR_STAB_CYC,
	parameter int SW_CYC   = `GPR_SWRST_CYC
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// axi4-lite slave
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// port a pins
	input  wire logic [A_W-1:0]    port_a_in,
	output logic [A_W-1:0]         port_a_out,
	output logic [A_W-1:0]         port_a_oe,
	output logic [A_W-1:0]         port_a_pullup_en,
	// port b pins
	input  wire logic [B_W-1:0]    port_b_in,
	output logic [B_W-1:0]         port_b_out,
	output logic [B_W-1:0]         port_b_oe,
	output logic [B_W-1:0]         port_b_pullup_en,
	// reset pin, open-drain
	input  wire logic              reset_pin_active_low_in,
	output logic                   reset_pin_active_low_out,
	output logic                   reset_pin_active_low_oe,
	// chip reset towards the core
	output logic                   chip_reset
);
	logic [A_W-1:0] port_a_latch, port_a_direction_reg, port_a_pullup_reg;
	logic [A_W-1:0] next_a_latch, next_a_dir, next_a_pu;
	logic [B_W-1:0] port_b_latch, port_b_direction_reg, port_b_pullup_reg;
	logic [B_W-1:0] next_b_latch, next_b_dir, next_b_pu;
	logic           reset_shared_port_bit, next_shared;
	gpr_state_e     state, next_state;
	logic [31:0]    cnt, next_cnt;
	logic           aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0]     aw_addr, next_aw_addr;
	logic [31:0]    w_data, next_w_data;
	logic [3:0]     w_strb, next_w_strb;
	logic           bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0]     bresp, next_bresp, rresp, next_rresp;
	logic [31:0]    rdata, next_rdata;
	logic           sw_req, init_hold;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `GPR_OFF_RST_STAT);
	endfunction

	// reset pin low or bus reset keeps all state initialised
	assign init_hold = rst || !reset_pin_active_low_in;

	// reset sequencer
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			GPR_ST_HOLD: begin
				next_state = GPR_ST_WAIT;
				next_cnt = 32'h0;
			end
			GPR_ST_WAIT: begin
				next_cnt = cnt + 32'h1;
				if (cnt >= 32'(STAB_CYC - 1)) begin
					next_state = GPR_ST_RUN;
				end
			end
			GPR_ST_RUN: begin
				if (sw_req) begin
					next_state = GPR_ST_SWRST;
					next_cnt = 32'h0;
				end
			end
			GPR_ST_SWRST: begin
				next_cnt = cnt + 32'h1;
				if (cnt >= 32'(SW_CYC - 1)) begin
					next_state = GPR_ST_RUN;
				end
			end
			default: next_state = GPR_ST_HOLD;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (init_hold) begin
			state <= GPR_ST_HOLD;
			cnt <= 32'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// register writes and axi handshakes
	always_comb begin
		next_a_latch = port_a_latch;
		next_a_dir = port_a_direction_reg;
		next_a_pu = port_a_pullup_reg;
		next_b_latch = port_b_latch;
		next_b_dir = port_b_direction_reg;
		next_b_pu = port_b_pullup_reg;
		next_shared = reset_shared_port_bit;
		next_aw_held = aw_held || s_axi_awvalid;
		next_w_held = w_held || s_axi_wvalid;
		next_aw_addr = (!aw_held && s_axi_awvalid) ? s_axi_awaddr : aw_addr;
		next_w_data = (!w_held && s_axi_wvalid) ? s_axi_wdata : w_data;
		next_w_strb = (!w_held && s_axi_wvalid) ? s_axi_wstrb : w_strb;
		next_bvalid = bvalid && !s_axi_bready;
		next_bresp = bresp;
		next_rvalid = rvalid && !s_axi_rready;
		next_rresp = rresp;
		next_rdata = rdata;
		sw_req = 1'b0;
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_addr) ? 2'b00 : 2'b10;
			case (aw_addr)
				`GPR_OFF_A_OUT: next_a_latch = A_W'(merge(32'(port_a_latch), w_data, w_strb));
				`GPR_OFF_A_DIR: next_a_dir = A_W'(merge(32'(port_a_direction_reg), w_data, w_strb));
				`GPR_OFF_A_PU: next_a_pu = A_W'(merge(32'(port_a_pullup_reg), w_data, w_strb));
				`GPR_OFF_B_OUT: next_b_latch = B_W'(merge(32'(port_b_latch), w_data, w_strb));
				`GPR_OFF_B_DIR: next_b_dir = B_W'(merge(32'(port_b_direction_reg), w_data, w_strb));
				`GPR_OFF_B_PU: next_b_pu = B_W'(merge(32'(port_b_pullup_reg), w_data, w_strb));
				`GPR_OFF_RST_CTRL: begin
					if (w_strb[0]) begin
						next_shared = w_data[`GPR_RST_LATCH_BIT];
						sw_req = w_data[`GPR_RST_SWREQ_BIT] && (state == GPR_ST_RUN);
					end
				end
				default: next_shared = reset_shared_port_bit;
			endcase
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
			case (s_axi_araddr)
				`GPR_OFF_A_OUT: next_rdata = 32'(port_a_latch);
				`GPR_OFF_A_DIR: next_rdata = 32'(port_a_direction_reg);
				`GPR_OFF_A_PU: next_rdata = 32'(port_a_pullup_reg);
				`GPR_OFF_A_IN: next_rdata = 32'(port_a_in);
				`GPR_OFF_B_OUT: next_rdata = 32'(port_b_latch);
				`GPR_OFF_B_DIR: next_rdata = 32'(port_b_direction_reg);
				`GPR_OFF_B_PU: next_rdata = 32'(port_b_pullup_reg);
				`GPR_OFF_B_IN: next_rdata = 32'(port_b_in);
				`GPR_OFF_RST_CTRL: next_rdata = 32'(reset_shared_port_bit);
				`GPR_OFF_RST_STAT: next_rdata = {30'h0, state == GPR_ST_SWRST,
					state == GPR_ST_RUN};
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (init_hold) begin
			port_a_latch <= '0;
			port_a_direction_reg <= '0;
			port_a_pullup_reg <= '0;
			port_b_latch <= '0;
			port_b_direction_reg <= '0;
			port_b_pullup_reg <= '0;
			reset_shared_port_bit <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
			rvalid <= 1'b0;
			rresp <= 2'b00;
			rdata <= 32'h0;
		end else begin
			port_a_latch <= next_a_latch;
			port_a_direction_reg <= next_a_dir;
			port_a_pullup_reg <= next_a_pu;
			port_b_latch <= next_b_latch;
			port_b_direction_reg <= next_b_dir;
			port_b_pullup_reg <= next_b_pu;
			reset_shared_port_bit <= next_shared;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	// pin drivers, all registered
	always_ff @(posedge core_clk) begin
		if (init_hold) begin
			port_a_out <= '0;
			port_a_oe <= '0;
			port_a_pullup_en <= '0;
			port_b_out <= '0;
			port_b_oe <= '0;
			port_b_pullup_en <= '0;
			reset_pin_active_low_oe <= 1'b0;
			chip_reset <= 1'b1;
			reset_pin_active_low_out <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_arready <= 1'b1;
		end else begin
			port_a_out <= next_a_latch;
			port_a_oe <= next_a_dir;
			port_a_pullup_en <= next_a_pu;
			port_b_out <= next_b_latch;
			port_b_oe <= next_b_dir;
			port_b_pullup_en <= next_b_pu;
			reset_pin_active_low_oe <= (next_state == GPR_ST_SWRST) && !next_shared;
			chip_reset <= (next_state != GPR_ST_RUN);
			reset_pin_active_low_out <= 1'b0;
			s_axi_awready <= !next_aw_held;
			s_axi_wready <= !next_w_held;
			s_axi_arready <= !next_rvalid;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;

	chk_reset_inputs: assert property (@(posedge core_clk) $fell(init_hold) |->
		port_a_oe == '0 && port_b_oe == '0 && port_a_pullup_en == '0 && port_b_pullup_en == '0)
		else $error("ports not inputs after reset");
	chk_stab_wait: assert property (@(posedge core_clk) disable iff (init_hold)
		(state == GPR_ST_WAIT && cnt < 32'(STAB_CYC - 1)) |=> chip_reset)
		else $error("chip reset released before stabilisation");
	chk_hold_low: assert property (@(posedge core_clk) init_hold |=> chip_reset)
		else $error("chip reset not held");
	chk_od_low: assert property (@(posedge core_clk) reset_pin_active_low_out == 1'b0)
		else $error("reset pin driven high");
	chk_swrst_drive: assert property (@(posedge core_clk) disable iff (init_hold)
		$rose(reset_pin_active_low_oe) |-> state == GPR_ST_SWRST && !reset_shared_port_bit)
		else $error("reset pin pulled without cause");
	chk_a_drive: assert property (@(posedge core_clk) disable iff (init_hold)
		1'b1 |=> port_a_out == $past(next_a_latch) && port_a_oe == port_a_direction_reg)
		else $error("port a pins disagree with registers");
	chk_b_drive: assert property (@(posedge core_clk) disable iff (init_hold)
		1'b1 |=> port_b_pullup_en == port_b_pullup_reg && port_b_oe == port_b_direction_reg)
		else $error("port b pins disagree with registers");
	chk_bresp_hold: assert property (@(posedge core_clk) disable iff (init_hold)
		bvalid && !s_axi_bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	cov_swrst: cover property (@(posedge core_clk) $rose(reset_pin_active_low_oe));
	cov_run: cover property (@(posedge core_clk) $fell(chip_reset));
	cov_out: cover property (@(posedge core_clk) port_a_oe != '0 && port_b_oe != '0);
endmodule

// ### sim/gpr_board.sv
`timescale 1ns/1ns
module gpr_board #(
	parameter int A_W = 7,
	parameter int B_W = 5
) (
	// clock
	input  wire logic           core_clk,
	input  wire logic           rst,
	// port a
	input  wire logic [A_W-1:0] a_out,
	input  wire logic [A_W-1:0] a_oe,
	input  wire logic [A_W-1:0] a_pu,
	input  wire logic [A_W-1:0] a_en,
	input  wire logic [A_W-1:0] a_val,
	output logic      [A_W-1:0] a_pin,
	// port b
	input  wire logic [B_W-1:0] b_out,
	input  wire logic [B_W-1:0] b_oe,
	input  wire logic [B_W-1:0] b_pu,
	input  wire logic [B_W-1:0] b_en,
	input  wire logic [B_W-1:0] b_val,
	output logic      [B_W-1:0] b_pin,
	// reset pin
	input  wire logic           rp_out,
	input  wire logic           rp_oe,
	input  wire logic           ext_low,
	output logic                rp_line
);
	logic flip;
	// floating lines wander every cycle; clocks from resonators only
	always_ff @(posedge core_clk) flip <= rst ? 1'b0 : ~flip;
	// chip drive wins, then board, then pull-up
	assign a_pin = (a_oe & a_out) | (~a_oe & a_en & a_val)
		| (~a_oe & ~a_en & (a_pu | {A_W{flip}}));
	assign b_pin = (b_oe & b_out) | (~b_oe & b_en & b_val)
		| (~b_oe & ~b_en & (b_pu | {B_W{flip}}));
	// external pull-up on the reset line
	assign rp_line = ~(rp_oe & ~rp_out) & ~ext_low;
endmodule

// ### sim/io_port_and_reset_pin_test.sv
`timescale 1ns/1ns
module io_port_and_reset_pin_test;
	localparam int STAB = 4;
	logic        core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, rp_in, rp_out, rp_oe, ext_low;
	logic        chip_reset, seen_low;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [6:0]  a_in, a_out, a_oe, a_pu, a_en, a_val;
	logic [4:0]  b_in, b_out, b_oe, b_pu, b_en, b_val;
	int          err_count, total_checks;
	gpr_top #(.STAB_CYC(STAB), .SW_CYC(3)) dut (.core_clk(core_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_in(a_in),
		.port_a_out(a_out), .port_a_oe(a_oe), .port_a_pullup_en(a_pu),
		.port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
		.port_b_pullup_en(b_pu), .reset_pin_active_low_in(rp_in),
		.reset_pin_active_low_out(rp_out), .reset_pin_active_low_oe(rp_oe),
		.chip_reset(chip_reset));
	gpr_board board (.core_clk(core_clk), .rst(rst), .a_out(a_out), .a_oe(a_oe),
		.a_pu(a_pu), .a_en(a_en), .a_val(a_val), .a_pin(a_in), .b_out(b_out),
		.b_oe(b_oe), .b_pu(b_pu), .b_en(b_en), .b_val(b_val), .b_pin(b_in),
		.rp_out(rp_out), .rp_oe(rp_oe), .ext_low(ext_low), .rp_line(rp_in));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// pin seen pulled low by the chip itself
	always @(posedge core_clk) if (rp_oe === 1'b1 && rp_in === 1'b0) seen_low <= 1'b1;
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ok;
		ok = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40 && !ok; n++) begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			ok = bvalid;
		end
		r = bresp;
		bready <= 1'b0;
		chk("write answer", ok, 1);
	endtask
	task automatic rd(input logic [7:0] a);
		logic ok;
		ok = 1'b0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40 && !ok; n++) begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
			ok = rvalid;
		end
		r = rresp;
		d = rdata;
		rready <= 1'b0;
		chk("read answer", ok, 1);
	endtask
	task automatic t_boot();
		int n;
		chk("a oe", a_oe, 0);
		chk("b oe", b_oe, 0);
		chk("a pullup", a_pu, 0);
		chk("b pullup", b_pu, 0);
		chk("pin oe", rp_oe, 0);
		chk("pin out", rp_out, 0);
		chk("chip reset", chip_reset, 1);
		for (n = 1; n <= 40; n++) begin
			@(posedge core_clk);
			#1;
			if (chip_reset === 1'b0) break;
		end
		chk("stab edges", n, STAB + 1);
	endtask
	task automatic t_ports();
		wr(8'h04, 32'h0f);
		wr(8'h00, 32'h55);
		wr(8'h08, 32'h70);
		wr(8'h14, 32'h15);
		wr(8'h10, 32'h1f);
		wr(8'h18, 32'h0a);
		chk("write resp", r, 2'b00);
		chk("a oe", a_oe, 7'h0f);
		chk("a latch", a_out, 7'h55);
		chk("a pullup", a_pu, 7'h70);
		chk("b oe", b_oe, 5'h15);
		chk("b pullup", b_pu, 5'h0a);
		chk("b latch", b_out, 5'h1f);
		a_en <= 7'h70;
		a_val <= 7'h20;
		repeat (3) @(posedge core_clk);
		rd(8'h0c);
		chk("a level", d, 32'h25);
		rd(8'h1c);
		chk("b level", d, 32'h1f);
		rd(8'h14);
		chk("b dir", d, 32'h15);
		rd(8'h00);
		chk("a latch reg", d, 32'h55);
	endtask
	task automatic t_err();
		rd(8'h30);
		chk("bad read resp", r, 2'b10);
		chk("bad read data", d, 0);
		wr(8'h30, 32'h1);
		chk("bad write resp", r, 2'b10);
	endtask
	task automatic wait_run();
		int n;
		for (n = 0; n < 60 && chip_reset !== 1'b0; n++) @(posedge core_clk);
		#1;
		chk("run again", chip_reset, 0);
	endtask
	task automatic t_swrst();
		seen_low <= 1'b0;
		wr(8'h20, 32'h3);
		wait_run();
		chk("latch high no pull", seen_low, 0);
		rd(8'h24);
		chk("status running", d, 32'h1);
		wr(8'h20, 32'h2);
		wait_run();
		chk("latch low pulls", seen_low, 1);
		chk("pin released", rp_oe, 0);
		chk("line high", rp_in, 1);
	endtask
	task automatic t_pin();
		wr(8'h04, 32'h7f);
		ext_low <= 1'b1;
		repeat (3) @(posedge core_clk);
		ext_low <= 1'b0;
		#1;
		t_boot();
		rd(8'h04);
		chk("dir cleared", d, 0);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready, ext_low} = 7'h40;
		{awaddr, araddr, wdata, a_en, a_val, b_en, b_val} = '0;
		{err_count, total_checks, seen_low} = '0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		t_boot();
		t_ports();
		t_err();
		t_swrst();
		t_pin();
		final_report();
	end
	initial begin
		#100000;
		err_count++;
		final_report();
	end
endmodule
